// ### epb_pkg.sv
// shared constants and types of the external pin bus interface
package epb_pkg;
  // bus phase clock: oscillator divided by four, stretch adds four
  localparam int unsigned OSC_DIV = 4;
  localparam logic [2:0] STRETCH_CYC = 3'h4;
  typedef enum logic [1:0] {
    EPB_ADDR0 = 2'h0,
    EPB_ADDR1 = 2'h1,
    EPB_DATA0 = 2'h3,
    EPB_DATA1 = 2'h2
  } epb_phase_t;
  // register indices; the byte address is four times the index
  localparam logic [15:0] IDX_A_DATA = 16'h1000;
  localparam logic [15:0] IDX_A_DIR = 16'h1001;
  localparam logic [15:0] IDX_G_DATA = 16'h1002;
  localparam logic [15:0] IDX_G_DIR = 16'h1003;
  localparam logic [15:0] IDX_B_DATA = 16'h1004;
  localparam logic [15:0] IDX_F_DATA = 16'h1005;
  localparam logic [15:0] IDX_C_DATA = 16'h1006;
  localparam logic [15:0] IDX_C_DIR = 16'h1007;
  localparam logic [15:0] IDX_D_DATA = 16'h1008;
  localparam logic [15:0] IDX_D_DIR = 16'h1009;
  localparam logic [15:0] IDX_E_DATA = 16'h100a;
  localparam logic [15:0] IDX_CTRL = 16'h1060;
  localparam logic [15:0] IDX_STAT = 16'h1061;
  localparam int unsigned CTRL_CS_EN = 0;
  localparam logic [7:0] PORT_RST = 8'h00;
  // latched mode pins: a high selects the external bus, b low special
  localparam int unsigned MODE_A_BIT = 0;
  localparam int unsigned MODE_B_BIT = 1;
  function automatic logic [15:0] epb_badr(input logic [15:0] idx);
    epb_badr = {idx[13:0], 2'h0};
  endfunction
endpackage

// ### epb_top.sv
// external pin bus interface: bus clock, expanded bus, ports, pins
// Overview of operation
// - bus phase clock is the oscillator divided by four
// - address goes out while E is low, data moves while E high
// - wait high at E rise holds E high four more oscillator cycles
// - wait low at E rise: E falls two oscillator cycles after rising
// - data strobe output is always the inverse of E
// - reset input starts device; failures pull reset pin low
// - mode pins held during reset are latched to pick the mode
// - after reset mode pin a pulses low at each instruction start
// - expanded and test modes drive read/write for each transfer
// - port b: output port, or address 15..8 when expanded
// - port c: data and direction, or external data bus when expanded
// - port a: data, direction, timer sharing, inputs after reset
// - port d: six bits with data, direction, serial sharing
// - active low request input gives a maskable interrupt request
// - second request input becomes non-maskable once x bit cleared
// - buffered copy of the oscillator is driven out
// - port f: output port, or address 7..0 when expanded
// - port g: eight bit port, upper four carry chip selects
//
// Implementation choice: the Avalon-MM slave port.
`timescale 1ns/1ns
`default_nettype none
module epb_top import epb_pkg::*; (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [15:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic ext_req,
  input wire logic ext_we,
  input wire logic [15:0] ext_addr,
  input wire logic [7:0] ext_wdata,
  output logic ext_ack,
  output logic [7:0] ext_rdata,
  output logic bus_e_clk,
  output logic data_strobe_out,
  input wire logic wait_pin,
  output logic rw_out,
  output wire logic osc_buffer_out,
  input wire logic watchdog_timeout,
  input wire logic clock_fail,
  output logic reset_pin_out,
  output logic reset_pin_oe,
  input wire logic mode_select_a,
  input wire logic mode_select_b,
  input wire logic instr_start,
  output logic instr_start_out,
  output logic instr_start_oe,
  output logic mode_expanded,
  output logic mode_special,
  input wire logic irq_n_pin,
  input wire logic nonmaskable_int_req_n,
  input wire logic ccr_x_mask,
  output logic irq_req,
  output logic nonmaskable_int_req_req,
  input wire logic [7:0] port_a_pins_in,
  output logic [7:0] port_a_pins_out,
  output logic [7:0] port_a_pins_oe,
  input wire logic [7:0] port_a_alt_en,
  input wire logic [7:0] port_a_alt_out,
  input wire logic [7:0] port_a_alt_oe,
  output logic [7:0] port_b_pins,
  input wire logic [7:0] port_c_pins_in,
  output logic [7:0] port_c_pins_out,
  output logic [7:0] port_c_pins_oe,
  input wire logic [5:0] port_d_pins_in,
  output logic [5:0] port_d_pins_out,
  output logic [5:0] port_d_pins_oe,
  input wire logic [5:0] port_d_alt_en,
  input wire logic [5:0] port_d_alt_out,
  input wire logic [5:0] port_d_alt_oe,
  input wire logic [7:0] port_e_pins,
  output logic [7:0] port_f_pins,
  input wire logic [7:0] port_g_pins_in,
  output logic [7:0] port_g_pins_out,
  output logic [7:0] port_g_pins_oe,
  input wire logic [3:0] chip_sel
);

  epb_phase_t phase_q, phase_d;
  logic [2:0] stretch_q;
  logic waitreq_q, mode_taken_q, cyc_act_q, cyc_we_q, cs_en_q;
  logic [1:0] mode_q;
  logic [15:0] cyc_addr_q;
  logic [7:0] cyc_wdata_q, rd_mux;
  logic [7:0] pa_data_q, pa_dir_q, pb_data_q, pc_data_q, pc_dir_q;
  logic [7:0] pf_data_q, pg_data_q, pg_dir_q;
  logic [5:0] pd_data_q, pd_dir_q;
  logic exp_bus, e_next, cyc_edge, cyc_start, wr_en, rd_take;

  assign exp_bus = mode_taken_q & mode_q[MODE_A_BIT];
  // straight clock copy: a flop cannot follow the oscillator itself
  assign osc_buffer_out = clk_sys;

  //////////////////////////////////////////////////////////////////////
  // bus phase clock
  always_comb begin
    case (phase_q)
      EPB_ADDR0: phase_d = EPB_ADDR1;
      EPB_ADDR1: phase_d = EPB_DATA0;
      EPB_DATA0: phase_d = EPB_DATA1;
      EPB_DATA1: phase_d = (stretch_q != 3'h0) ? EPB_DATA1 : EPB_ADDR0;
      default: phase_d = EPB_ADDR0;
    endcase
  end
  assign e_next = (phase_d == EPB_DATA0) | (phase_d == EPB_DATA1);
  assign cyc_edge = (phase_q == EPB_DATA1) & (phase_d == EPB_ADDR0);
  assign cyc_start = cyc_edge & ~cyc_act_q & ext_req & exp_bus;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      phase_q <= EPB_ADDR0;
    end else begin
      phase_q <= phase_d;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      stretch_q <= 3'h0;
    end else if (phase_q == EPB_ADDR1) begin
      // wait is taken on the edge that raises E
      stretch_q <= wait_pin ? STRETCH_CYC : 3'h0;
    end else if (phase_q == EPB_DATA1 && stretch_q != 3'h0) begin
      stretch_q <= stretch_q - 3'h1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      bus_e_clk <= 1'b0;
      data_strobe_out <= 1'b1;
    end else begin
      bus_e_clk <= e_next;
      data_strobe_out <= ~e_next;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // external bus cycles
  // a request is taken only at a cycle boundary with no cycle ending,
  // so a request still held after its ack is served again at the next boundary
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cyc_act_q <= 1'b0;
      cyc_we_q <= 1'b0;
      cyc_addr_q <= 16'h0000;
      cyc_wdata_q <= 8'h00;
      rw_out <= 1'b1;
      ext_ack <= 1'b0;
      ext_rdata <= 8'h00;
    end else begin
      ext_ack <= cyc_edge & cyc_act_q;
      if (cyc_edge && cyc_act_q) begin
        cyc_act_q <= 1'b0;
        rw_out <= 1'b1;
        if (!cyc_we_q) begin
          ext_rdata <= port_c_pins_in;
        end
      end
      if (cyc_start) begin
        cyc_act_q <= 1'b1;
        cyc_we_q <= ext_we;
        cyc_addr_q <= ext_addr;
        cyc_wdata_q <= ext_wdata;
        rw_out <= ~ext_we;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // reset pin, mode latch, instruction start, interrupt requests
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      reset_pin_out <= 1'b0;
      reset_pin_oe <= 1'b0;
    end else begin
      reset_pin_out <= 1'b0;
      reset_pin_oe <= watchdog_timeout | clock_fail;
    end
  end

  // the pins are caught on the first edge after release
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      mode_taken_q <= 1'b0;
      mode_q <= 2'h0;
    end else if (!mode_taken_q) begin
      mode_taken_q <= 1'b1;
      mode_q <= {mode_select_b, mode_select_a};
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      mode_expanded <= 1'b0;
      mode_special <= 1'b0;
      instr_start_out <= 1'b0;
      instr_start_oe <= 1'b0;
    end else begin
      mode_expanded <= mode_taken_q & mode_q[MODE_A_BIT];
      mode_special <= mode_taken_q & ~mode_q[MODE_B_BIT];
      instr_start_out <= 1'b0;
      instr_start_oe <= mode_taken_q & instr_start;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      irq_req <= 1'b0;
      nonmaskable_int_req_req <= 1'b0;
    end else begin
      irq_req <= ~irq_n_pin;
      nonmaskable_int_req_req <= ~nonmaskable_int_req_n & ~ccr_x_mask;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // register bus: one wait cycle, then the access completes
  assign wr_en = avs_write & ~waitreq_q & avs_byteenable[0];
  assign rd_take = avs_read & waitreq_q;

  always_comb begin
    case (avs_address)
      epb_badr(IDX_A_DATA):
        rd_mux = (pa_data_q & pa_dir_q) | (port_a_pins_in & ~pa_dir_q);
      epb_badr(IDX_A_DIR): rd_mux = pa_dir_q;
      epb_badr(IDX_G_DATA):
        rd_mux = (pg_data_q & pg_dir_q) | (port_g_pins_in & ~pg_dir_q);
      epb_badr(IDX_G_DIR): rd_mux = pg_dir_q;
      epb_badr(IDX_B_DATA): rd_mux = pb_data_q;
      epb_badr(IDX_F_DATA): rd_mux = pf_data_q;
      epb_badr(IDX_C_DATA):
        rd_mux = (pc_data_q & pc_dir_q) | (port_c_pins_in & ~pc_dir_q);
      epb_badr(IDX_C_DIR): rd_mux = pc_dir_q;
      epb_badr(IDX_D_DATA): rd_mux = {2'h0,
        (pd_data_q & pd_dir_q) | (port_d_pins_in & ~pd_dir_q)};
      epb_badr(IDX_D_DIR): rd_mux = {2'h0, pd_dir_q};
      // sampling by the converter is not seen here; software must wait
      epb_badr(IDX_E_DATA): rd_mux = port_e_pins;
      epb_badr(IDX_CTRL): rd_mux = {7'h00, cs_en_q};
      epb_badr(IDX_STAT):
        rd_mux = {4'h0, bus_e_clk, cyc_act_q, mode_q};
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      waitreq_q <= 1'b1;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
    end else begin
      waitreq_q <= ~((avs_read | avs_write) & waitreq_q);
      avs_waitrequest <= ~((avs_read | avs_write) & waitreq_q);
      if (rd_take) begin
        avs_readdata <= {24'h000000, rd_mux};
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pa_data_q <= PORT_RST;
      pa_dir_q <= PORT_RST;
      pb_data_q <= PORT_RST;
      pc_data_q <= PORT_RST;
      pc_dir_q <= PORT_RST;
      pd_data_q <= 6'h00;
      pd_dir_q <= 6'h00;
      pf_data_q <= PORT_RST;
      pg_data_q <= PORT_RST;
      pg_dir_q <= PORT_RST;
      cs_en_q <= 1'b0;
    end else if (wr_en) begin
      case (avs_address)
        epb_badr(IDX_A_DATA): pa_data_q <= avs_writedata[7:0];
        epb_badr(IDX_A_DIR): pa_dir_q <= avs_writedata[7:0];
        epb_badr(IDX_G_DATA): pg_data_q <= avs_writedata[7:0];
        epb_badr(IDX_G_DIR): pg_dir_q <= avs_writedata[7:0];
        epb_badr(IDX_B_DATA): pb_data_q <= avs_writedata[7:0];
        epb_badr(IDX_F_DATA): pf_data_q <= avs_writedata[7:0];
        epb_badr(IDX_C_DATA): pc_data_q <= avs_writedata[7:0];
        epb_badr(IDX_C_DIR): pc_dir_q <= avs_writedata[7:0];
        epb_badr(IDX_D_DATA): pd_data_q <= avs_writedata[5:0];
        epb_badr(IDX_D_DIR): pd_dir_q <= avs_writedata[5:0];
        epb_badr(IDX_CTRL): cs_en_q <= avs_writedata[CTRL_CS_EN];
        default: cs_en_q <= cs_en_q;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////
  // pin drivers
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      port_a_pins_out <= PORT_RST;
      port_a_pins_oe <= PORT_RST;
      port_d_pins_out <= 6'h00;
      port_d_pins_oe <= 6'h00;
    end else begin
      // timer and serial functions take a pin over bit by bit
      port_a_pins_out <= (port_a_alt_en & port_a_alt_out) |
                         (~port_a_alt_en & pa_data_q);
      port_a_pins_oe <= (port_a_alt_en & port_a_alt_oe) |
                        (~port_a_alt_en & pa_dir_q);
      port_d_pins_out <= (port_d_alt_en & port_d_alt_out) |
                         (~port_d_alt_en & pd_data_q);
      port_d_pins_oe <= (port_d_alt_en & port_d_alt_oe) |
                        (~port_d_alt_en & pd_dir_q);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      port_b_pins <= PORT_RST;
      port_f_pins <= PORT_RST;
    end else if (!exp_bus) begin
      port_b_pins <= pb_data_q;
      port_f_pins <= pf_data_q;
    end else if (cyc_start) begin
      port_b_pins <= ext_addr[15:8];
      port_f_pins <= ext_addr[7:0];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      port_c_pins_out <= PORT_RST;
      port_c_pins_oe <= PORT_RST;
    end else if (exp_bus) begin
      port_c_pins_out <= cyc_wdata_q;
      port_c_pins_oe <= {8{e_next & cyc_act_q & cyc_we_q}};
    end else begin
      port_c_pins_out <= pc_data_q;
      port_c_pins_oe <= pc_dir_q;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      port_g_pins_out <= PORT_RST;
      port_g_pins_oe <= PORT_RST;
    end else begin
      port_g_pins_out[3:0] <= pg_data_q[3:0];
      port_g_pins_oe[3:0] <= pg_dir_q[3:0];
      port_g_pins_out[7:4] <= cs_en_q ? chip_sel : pg_data_q[7:4];
      port_g_pins_oe[7:4] <= cs_en_q ? 4'hf : pg_dir_q[7:4];
    end
  end

  //////////////////////////////////////////////////////////////////////
  // checks
  property p_low_two;
    @(posedge clk_sys) disable iff (!rst_b)
      $fell(bus_e_clk) |-> !bus_e_clk ##1 !bus_e_clk ##1 bus_e_clk;
  endproperty
  a_low_two: assert property (p_low_two)
    else $error("bus clock low phase not two cycles");

  property p_stretch;
    @(posedge clk_sys) disable iff (!rst_b)
      $rose(bus_e_clk) && $past(wait_pin) |->
        bus_e_clk[*6] ##1 !bus_e_clk;
  endproperty
  a_stretch: assert property (p_stretch)
    else $error("stretched high phase not six cycles");

  property p_nostretch;
    @(posedge clk_sys) disable iff (!rst_b)
      $rose(bus_e_clk) && !$past(wait_pin) |->
        bus_e_clk[*2] ##1 !bus_e_clk;
  endproperty
  a_nostretch: assert property (p_nostretch)
    else $error("plain high phase not two cycles");

  property p_strobe;
    @(posedge clk_sys) disable iff (!rst_b)
      data_strobe_out != bus_e_clk;
  endproperty
  a_strobe: assert property (p_strobe)
    else $error("data strobe not inverse of bus clock");

  property p_fail_pull;
    @(posedge clk_sys) disable iff (!rst_b)
      watchdog_timeout |=> reset_pin_oe && !reset_pin_out;
  endproperty
  a_fail_pull: assert property (p_fail_pull)
    else $error("failure did not pull reset pin");

  property p_rw;
    @(posedge clk_sys) disable iff (!rst_b)
      cyc_act_q |-> rw_out == !cyc_we_q;
  endproperty
  a_rw: assert property (p_rw)
    else $error("read/write output wrong during cycle");

  property p_addr;
    @(posedge clk_sys) disable iff (!rst_b)
      cyc_act_q && exp_bus |-> {port_b_pins, port_f_pins} == cyc_addr_q;
  endproperty
  a_addr: assert property (p_addr)
    else $error("address pins differ from cycle address");

  property p_data_high;
    @(posedge clk_sys) disable iff (!rst_b)
      exp_bus && (port_c_pins_oe != 8'h00) |-> bus_e_clk && cyc_we_q;
  endproperty
  a_data_high: assert property (p_data_high)
    else $error("data bus driven outside write data phase");

  property p_dir_a;
    @(posedge clk_sys) disable iff (!rst_b)
      wr_en && avs_address == epb_badr(IDX_A_DIR) && port_a_alt_en == 8'h00
        ##1 port_a_alt_en == 8'h00 |=>
        port_a_pins_oe == $past(avs_writedata[7:0], 2);
  endproperty
  a_dir_a: assert property (p_dir_a)
    else $error("port a enables do not follow direction write");

  property p_irq;
    @(posedge clk_sys) disable iff (!rst_b)
      !irq_n_pin |=> irq_req;
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt request not raised");

  property p_lir;
    @(posedge clk_sys) disable iff (!rst_b)
      mode_taken_q && instr_start |=> instr_start_oe;
  endproperty
  a_lir: assert property (p_lir)
    else $error("instruction start not pulsed");

endmodule
`default_nettype wire

// ### epb_ext_mem.sv
// external memory model on the expanded bus of epb_top
`timescale 1ns/1ns
`default_nettype none
module epb_ext_mem (
  input wire logic clk_sys,
  input wire logic bus_e_clk,
  input wire logic rw_out,
  input wire logic [7:0] addr_hi,
  input wire logic [7:0] addr_lo,
  input wire logic [7:0] bus_out,
  input wire logic [7:0] bus_oe,
  input wire logic slow,
  output logic [7:0] bus_drive,
  output logic wait_pin,
  output logic [15:0] seen_addr,
  output logic [7:0] seen_wdata
);
  logic [7:0] mem [256];
  logic [7:0] last_q;
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'(i);
    end
    {last_q, seen_wdata, seen_addr} = '0;
    wait_pin = 1'b0;
  end
  ////////////////////////////////////////////////
  // a slow part asks for the stretch before every rise of e
  always @(posedge clk_sys) begin
    wait_pin <= slow;
    if (bus_e_clk && rw_out) begin
      last_q <= mem[addr_lo];
    end
    if (bus_e_clk) begin
      seen_addr <= {addr_hi, addr_lo};
      if (!rw_out) begin
        mem[addr_lo] <= bus_out & bus_oe;
        seen_wdata <= bus_out & bus_oe;
      end
    end
  end
  // released bus shows the inverse of its last value, never stale data
  assign bus_drive = (bus_e_clk && rw_out) ? mem[addr_lo] : ~last_q;
endmodule
`default_nettype wire

// ### tb_top.sv
// self-checking testbench of epb_top with an external memory
`timescale 1ns/1ns
`default_nettype none
module tb_top import epb_pkg::*;;
  logic clk_sys, rst_b, avs_read, avs_write, avs_waitrequest, ext_req;
  logic ext_we, ext_ack, bus_e_clk, data_strobe_out, wait_pin, rw_out;
  logic osc_buffer_out, watchdog_timeout, clock_fail, reset_pin_out;
  logic reset_pin_oe, mode_select_a, mode_select_b, instr_start;
  logic instr_start_out, instr_start_oe, mode_expanded, mode_special;
  logic irq_n_pin, nonmaskable_int_req_n, ccr_x_mask, irq_req, nonmaskable_int_req_req;
  logic [15:0] avs_address, ext_addr, seen_addr, a;
  logic [3:0] avs_byteenable, chip_sel;
  logic [31:0] avs_writedata, avs_readdata, r;
  logic [7:0] ext_wdata, ext_rdata, port_a_pins_in, port_a_pins_out;
  logic [7:0] port_a_pins_oe, port_a_alt_en, port_a_alt_out, port_a_alt_oe;
  logic [7:0] port_b_pins, port_c_pins_in, port_c_pins_out, port_c_pins_oe;
  logic [7:0] port_e_pins, port_f_pins, port_g_pins_in, port_g_pins_out;
  logic [7:0] port_g_pins_oe, c_stim, mem_drv, seen_wdata, oe, ov, d;
  logic [5:0] port_d_pins_in, port_d_pins_out, port_d_pins_oe;
  logic [5:0] port_d_alt_en, port_d_alt_out, port_d_alt_oe;
  logic slow, ext_on, acked, seen_fall, w_last;
  int bad_count = 0;
  int comparisons = 0;
  int hi_n, lo_n;
  localparam logic [15:0] DAT_I [4] = '{IDX_A_DATA, IDX_C_DATA,
    IDX_D_DATA, IDX_G_DATA};
  localparam logic [15:0] DIR_I [4] = '{IDX_A_DIR, IDX_C_DIR,
    IDX_D_DIR, IDX_G_DIR};
  localparam logic [7:0] WID [4] = '{8'hff, 8'hff, 8'h3f, 8'hff};

  epb_top DUT (.*);
  epb_ext_mem MEM (.clk_sys(clk_sys), .bus_e_clk(bus_e_clk),
    .rw_out(rw_out), .addr_hi(port_b_pins), .addr_lo(port_f_pins),
    .bus_out(port_c_pins_out), .bus_oe(port_c_pins_oe), .slow(slow),
    .bus_drive(mem_drv), .wait_pin(wait_pin), .seen_addr(seen_addr),
    .seen_wdata(seen_wdata));
  // data pins see whoever drives: the design, the memory or the bench
  assign port_c_pins_in = (port_c_pins_oe & port_c_pins_out) |
    (~port_c_pins_oe & (ext_on ? mem_drv : c_stim));

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  ////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("comparisons %0d, bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic settle;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask
  task automatic bus(input logic w, input logic [15:0] idx,
      input logic [7:0] wd, input logic [3:0] be, output logic [31:0] rdv);
    int n;
    @(posedge clk_sys);
    avs_address <= {idx[13:0], 2'h0};
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= {24'h0, wd};
    avs_byteenable <= be;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    rdv = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 20) begin
      bad_count++;
      tally_and_finish;
    end
  endtask
  task automatic wr(input logic [15:0] idx, input logic [7:0] wd);
    logic [31:0] dummy;
    bus(1'b1, idx, wd, 4'h1, dummy);
  endtask
  task automatic rd(input logic [15:0] idx, output logic [31:0] rdv);
    bus(1'b0, idx, 8'h00, 4'h1, rdv);
  endtask
  // requests are spaced a full bus cycle apart, as the core must
  task automatic ext(input logic we, input logic [15:0] ad,
      input logic [7:0] wd);
    int n;
    @(posedge clk_sys);
    ext_req <= 1'b1;
    ext_we <= we;
    ext_addr <= ad;
    ext_wdata <= wd;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (ext_ack !== 1'b1 && n < 60);
    acked = (ext_ack === 1'b1);
    ext_req <= 1'b0;
    repeat (8) @(posedge clk_sys);
  endtask
  task automatic do_reset(input logic [1:0] m);
    rst_b <= 1'b0;
    mode_select_a <= m[0];
    mode_select_b <= m[1];
    repeat (6) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk_sys);
  endtask
  ////////////////////////////////////////////////
  always @(negedge clk_sys) begin
    // an unknown reset at time zero counts as reset, not as a run
    if (rst_b !== 1'b1) begin
      {hi_n, lo_n, seen_fall, w_last} = '0;
    end else begin
      chk(data_strobe_out, !bus_e_clk);
      chk(port_c_pins_oe & {8{mode_expanded & !bus_e_clk}}, 0);
      if (bus_e_clk) begin
        if (lo_n > 0 && seen_fall) begin
          chk(lo_n, 2);
        end
        lo_n = 0;
        hi_n++;
      end else begin
        if (hi_n > 0) begin
          chk(hi_n, w_last ? 6 : 2);
          seen_fall = 1'b1;
        end
        hi_n = 0;
        lo_n++;
        w_last = wait_pin;
      end
      // the copied clock settles after the edge itself, so look later
      #5;
      chk(osc_buffer_out, clk_sys);
    end
  end
  initial begin
    repeat (30000) @(posedge clk_sys);
    bad_count++;
    tally_and_finish;
  end
  initial begin
    {rst_b, avs_read, avs_write, ext_req, ext_we, watchdog_timeout} = '0;
    {clock_fail, instr_start, ccr_x_mask, slow, ext_on} = '0;
    {irq_n_pin, nonmaskable_int_req_n, mode_select_a, mode_select_b} = 4'hc;
    {avs_address, avs_writedata, avs_byteenable} = '0;
    {ext_addr, ext_wdata, chip_sel, port_e_pins, port_g_pins_in} = '0;
    {port_a_pins_in, port_a_alt_en, port_a_alt_out, port_a_alt_oe} = '0;
    {port_d_pins_in, port_d_alt_en, port_d_alt_out, port_d_alt_oe} = '0;
    c_stim = '0;
    for (int m = 3; m >= 0; m--) begin
      do_reset(m[1:0]);
      chk(mode_expanded, m[0]);
      chk(mode_special, !m[1]);
      rd(IDX_STAT, r);
      chk(r & 32'h3, m);
    end
    chk(port_a_pins_oe, 8'h00);
    port_a_pins_in <= 8'hc3;
    c_stim <= 8'hc3;
    port_d_pins_in <= 6'h03;
    port_g_pins_in <= 8'hc3;
    port_e_pins <= 8'h96;
    for (int p = 0; p < 4; p++) begin
      rd(DIR_I[p], r);
      chk(r, 0);
      wr(DIR_I[p], 8'h0f);
      wr(DAT_I[p], 8'h5a);
      settle;
      case (p)
        0: {oe, ov} = {port_a_pins_oe, port_a_pins_out};
        1: {oe, ov} = {port_c_pins_oe, port_c_pins_out};
        2: {oe, ov} = {2'h0, port_d_pins_oe, 2'h0, port_d_pins_out};
        default: {oe, ov} = {port_g_pins_oe, port_g_pins_out};
      endcase
      chk(oe, 8'h0f);
      chk(ov & oe, 8'h0a);
      rd(DAT_I[p], r);
      chk(r, 8'hca & WID[p]);
      rd(DIR_I[p], r);
      chk(r, 8'h0f & WID[p]);
    end
    rd(IDX_E_DATA, r);
    chk(r, 8'h96);
    wr(IDX_B_DATA, 8'h3c);
    wr(IDX_F_DATA, 8'hc3);
    bus(1'b1, IDX_B_DATA, 8'hff, 4'h0, r);
    wr(16'h1020, 8'hff);
    rd(16'h1020, r);
    chk(r, 0);
    chk({port_b_pins, port_f_pins}, 16'h3cc3);
    ext(1'b1, 16'h2034, 8'h11);
    chk(acked, 0);
    chk(port_b_pins, 8'h3c);
    wr(IDX_CTRL, 8'h01);
    chip_sel <= 4'ha;
    port_a_alt_en <= 8'h80;
    port_a_alt_out <= 8'h80;
    port_a_alt_oe <= 8'h80;
    port_d_alt_en <= 6'h20;
    port_d_alt_out <= 6'h20;
    port_d_alt_oe <= 6'h20;
    settle;
    chk({port_g_pins_oe[7:4], port_g_pins_out[7:4]}, 8'hfa);
    chk({port_a_pins_oe[7], port_a_pins_out[7]}, 2'h3);
    chk({port_d_pins_oe[5], port_d_pins_out[5]}, 2'h3);
    @(posedge clk_sys);
    instr_start <= 1'b1;
    irq_n_pin <= 1'b0;
    nonmaskable_int_req_n <= 1'b0;
    ccr_x_mask <= 1'b1;
    @(posedge clk_sys);
    instr_start <= 1'b0;
    @(negedge clk_sys);
    chk({instr_start_oe, instr_start_out}, 2'h2);
    @(negedge clk_sys);
    chk({instr_start_oe, irq_req, nonmaskable_int_req_req}, 3'h2);
    @(posedge clk_sys);
    ccr_x_mask <= 1'b0;
    irq_n_pin <= 1'b1;
    settle;
    chk({irq_req, nonmaskable_int_req_req}, 2'h1);
    for (int i = 0; i < 2; i++) begin
      @(posedge clk_sys);
      {clock_fail, watchdog_timeout} <= 2'(i + 1);
      settle;
      chk({reset_pin_oe, reset_pin_out}, 2'h2);
    end
    @(posedge clk_sys);
    clock_fail <= 1'b0;
    settle;
    chk(reset_pin_oe, 0);
    do_reset(2'h3);
    ext_on <= 1'b1;
    for (int s = 0; s < 2; s++) begin
      a = 16'h2034 + 16'(s);
      d = 8'ha5 + 8'(s);
      slow <= s[0];
      ext(1'b1, a, d);
      chk(acked, 1);
      chk(seen_wdata, d);
      chk({port_b_pins, port_f_pins}, a);
      chk(seen_addr, a);
      ext(1'b0, a, 8'h00);
      chk(ext_rdata, d);
    end
    tally_and_finish;
  end
endmodule
`default_nettype wire
